// >>> pkg/cfm_pkg.sv
// shared constants and carrier types for the current fault monitor
package cfm_pkg;
   localparam int unsigned CLK_HZ       = 200_000_000;
   localparam int unsigned STAB_TIME_US = 6000;
   localparam int unsigned STAB_CYCLES  = (STAB_TIME_US * (CLK_HZ / 1_000_000));
   // default delays in microseconds, redefinable per product code
   localparam int unsigned OCU_DET_US   = 10000;
   localparam int unsigned OCU_REL_US   = 10000;
   localparam int unsigned OCO_DET_US   = 10000;
   localparam int unsigned OCO_REL_US   = 10000;
   localparam int unsigned SC_DET_US    = 300;
   localparam int unsigned SC_REL_US    = 10000;
   localparam int unsigned WK_DET_US    = 1000;
   localparam int unsigned UVR_REL_US   = 10000;
   localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;
   localparam int unsigned CNT_W        = 32;
   localparam int unsigned CELLS_MAX    = 5;
   // release count for levels that drop out at once
   localparam int unsigned QUICK_REL_CYC = 1;

   // interrupt request flags
   typedef struct packed {
      logic wake_event_req;
      logic short_circuit_req;
      logic chg_overcurrent_req;
      logic dischg_overcurrent_req;
   } irq_req_s;

   // error flags
   typedef struct packed {
      logic under_volt_err;
      logic short_circuit_err;
      logic chg_overcurrent_err;
      logic dischg_overcurrent_err;
   } err_flags_s;

   // qualified comparator levels
   typedef struct packed {
      logic wake_above;
      logic sc_above;
      logic oco_above;
      logic ocu_above;
   } cmp_s;

   localparam irq_req_s   IRQ_RESET = '{default: 1'b0};
   localparam err_flags_s ERR_RESET = '{under_volt_err: 1'b1, default: 1'b0};
endpackage

// >>> design/pin_sync.sv
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module pin_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// >>> design/delay_qual.sv
// level qualifier: output follows input after it holds for set/release counts
`timescale 1ns/1ps
module delay_qual #(
   parameter int unsigned SET_CYC = 4,
   parameter int unsigned REL_CYC = 4
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_n,
   // control
   input  wire logic clr,
   input  wire logic level,
   output logic      state
);
   localparam int unsigned W = 32;
   logic [W-1:0] cnt;
   logic [W-1:0] limit;

   always_comb begin
      limit = state ? W'(REL_CYC) : W'(SET_CYC);
   end

   // counter restarts whenever the level matches the held state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt   <= '0;
         state <= 1'b0;
      end else if (clr) begin
         cnt   <= '0;
         state <= 1'b0;
      end else if (level == state) begin
         cnt <= '0;
      end else if (cnt >= limit - W'(1)) begin
         cnt   <= '0;
         state <= level;
      end else begin
         cnt <= cnt + W'(1);
      end
   end
endmodule

// >>> design/current_fault_monitor.sv
// current fault state logic with request and error flags
// Summary of operation
// - shunt above discharge limit sets fault, irq
// - discharge fault entry sets its request flag
// - reading request register clears flags, irq
// - discharge fault entry sets error, error low
// - below limit past release delay clears error
// - charge overcurrent past delay sets fault, irq
// - charge fault entry sets its request flag
// - charge fault entry sets error, error low
// - charge release delay clears charge error
// - short circuit sets indicator, irq, request
// - short circuit error set, cleared after release
// - error pin released only with no errors
// - fault release raises no interrupt
// - wake detection waits for stabilisation interval
// - enabled wake past delay sets irq, request
// - read clears wake request, releases irq
// - wake leaves error output and bits alone
// - regulator drop resets state, sets undervoltage
// - undervoltage clears after cells stay good
// - four or five cell stacks supported
// - overcurrent monitoring only after stabilisation
`timescale 1ns/1ps
module current_fault_monitor #(
   parameter int unsigned STAB_CYC = cfm_pkg::STAB_CYCLES,
   parameter int unsigned OCU_DET  = cfm_pkg::OCU_DET_US * cfm_pkg::CYC_PER_US,
   parameter int unsigned OCU_REL  = cfm_pkg::OCU_REL_US * cfm_pkg::CYC_PER_US,
   parameter int unsigned OCO_DET  = cfm_pkg::OCO_DET_US * cfm_pkg::CYC_PER_US,
   parameter int unsigned OCO_REL  = cfm_pkg::OCO_REL_US * cfm_pkg::CYC_PER_US,
   parameter int unsigned SC_DET   = cfm_pkg::SC_DET_US * cfm_pkg::CYC_PER_US,
   parameter int unsigned SC_REL   = cfm_pkg::SC_REL_US * cfm_pkg::CYC_PER_US,
   parameter int unsigned WK_DET   = cfm_pkg::WK_DET_US * cfm_pkg::CYC_PER_US,
   parameter int unsigned UVR_REL  = cfm_pkg::UVR_REL_US * cfm_pkg::CYC_PER_US
) (
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   // comparator results from the analog front end (asynchronous)
   input  wire logic                  ocu_cmp,
   input  wire logic                  oco_cmp,
   input  wire logic                  sc_cmp,
   input  wire logic                  wake_cmp,
   input  wire logic [4:0]            cell_above_uvr,
   input  wire logic                  regulator_ok,
   // configuration
   input  wire logic                  wake_enable_bit,
   input  wire logic                  five_cells,
   // register port side
   input  wire logic                  irq_read,
   output cfm_pkg::irq_req_s          irq_request_reg,
   output cfm_pkg::err_flags_s        error_reg,
   // open-drain pins: enable high pulls the pin low; monitor_active is a plain output
   output logic                       int_out,
   output logic                       int_oe,
   output logic                       err_out,
   output logic                       err_oe,
   output logic                       short_detect_out,
   output logic                       short_detect_oe,
   output logic                       monitor_active
);
   typedef enum logic [2:0] {
      ST_DROP   = 3'b001,
      ST_STAB   = 3'b010,
      ST_ACTIVE = 3'b100
   } pwr_e;

   pwr_e                state;
   pwr_e                next_state;
   logic [31:0]         stab_cnt;
   cfm_pkg::cmp_s       cmp_raw;
   cfm_pkg::cmp_s       cmp;
   cfm_pkg::cmp_s       qual;
   cfm_pkg::cmp_s       qual_d;
   logic [4:0]          cells_s;
   logic                reg_ok;
   logic                all_cells_ok;
   logic                cells_qual;
   logic                mon_clr;
   logic                wake_clr;
   cfm_pkg::irq_req_s   rise;
   logic                cells_qual_d;

   assign cmp_raw = '{wake_above: wake_cmp, sc_above: sc_cmp,
                      oco_above: oco_cmp, ocu_above: ocu_cmp};

   // pin levels cross into mclk through two flops
   pin_sync #(.W(4)) u_cmp_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     (cmp_raw),
      .q     (cmp)
   );

   pin_sync #(.W(6)) u_misc_sync (
      .mclk  (mclk),
      .rst_n (rst_n),
      .d     ({regulator_ok, cell_above_uvr}),
      .q     ({reg_ok, cells_s})
   );

   // in a four-cell stack the lowest input is grounded and ignored
   always_comb begin
      all_cells_ok = &cells_s[4:1] & (cells_s[0] | ~five_cells);
   end

   // regulator drop, stabilisation, active
   always_comb begin
      next_state = state;
      case (state)
         ST_DROP: begin
            if (reg_ok) begin
               next_state = ST_STAB;
            end
         end
         ST_STAB: begin
            if (!reg_ok) begin
               next_state = ST_DROP;
            end else if (stab_cnt >= 32'(STAB_CYC) - 32'd1) begin
               next_state = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (!reg_ok) begin
               next_state = ST_DROP;
            end
         end
         default: next_state = ST_DROP;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_DROP;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stab_cnt <= '0;
      end else if (state != ST_STAB) begin
         stab_cnt <= '0;
      end else begin
         stab_cnt <= stab_cnt + 32'd1;
      end
   end

   // current and wake qualifiers are held cleared outside the active state
   assign mon_clr  = (state != ST_ACTIVE);
   assign wake_clr = mon_clr | ~wake_enable_bit;

   delay_qual #(.SET_CYC(OCU_DET), .REL_CYC(OCU_REL)) u_ocu (
      .mclk  (mclk),
      .rst_n (rst_n),
      .clr   (mon_clr),
      .level (cmp.ocu_above),
      .state (qual.ocu_above)
   );

   delay_qual #(.SET_CYC(OCO_DET), .REL_CYC(OCO_REL)) u_oco (
      .mclk  (mclk),
      .rst_n (rst_n),
      .clr   (mon_clr),
      .level (cmp.oco_above),
      .state (qual.oco_above)
   );

   delay_qual #(.SET_CYC(SC_DET), .REL_CYC(SC_REL)) u_sc (
      .mclk  (mclk),
      .rst_n (rst_n),
      .clr   (mon_clr),
      .level (cmp.sc_above),
      .state (qual.sc_above)
   );

   delay_qual #(.SET_CYC(WK_DET), .REL_CYC(cfm_pkg::QUICK_REL_CYC)) u_wake (
      .mclk  (mclk),
      .rst_n (rst_n),
      .clr   (wake_clr),
      .level (cmp.wake_above),
      .state (qual.wake_above)
   );

   // cell release uses the same qualifier; it runs once the regulator is back
   delay_qual #(.SET_CYC(UVR_REL), .REL_CYC(cfm_pkg::QUICK_REL_CYC)) u_uvr (
      .mclk  (mclk),
      .rst_n (rst_n),
      .clr   (state == ST_DROP),
      .level (all_cells_ok),
      .state (cells_qual)
   );

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         qual_d       <= '0;
         cells_qual_d <= 1'b0;
      end else begin
         qual_d       <= qual;
         cells_qual_d <= cells_qual;
      end
   end

   // only entries make requests; releases never do
   always_comb begin
      rise.dischg_overcurrent_req = qual.ocu_above & ~qual_d.ocu_above;
      rise.chg_overcurrent_req    = qual.oco_above & ~qual_d.oco_above;
      rise.short_circuit_req      = qual.sc_above & ~qual_d.sc_above;
      rise.wake_event_req         = qual.wake_above & ~qual_d.wake_above;
   end

   // request flags: a new event wins over a read in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_request_reg <= cfm_pkg::IRQ_RESET;
      end else if (state == ST_DROP) begin
         irq_request_reg <= cfm_pkg::IRQ_RESET;
      end else if (irq_read) begin
         irq_request_reg <= rise;
      end else begin
         irq_request_reg <= irq_request_reg | rise;
      end
   end

   // current error flags track qualified states, undervoltage clears on cell release; wake never touches them
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         error_reg <= cfm_pkg::ERR_RESET;
      end else if (state == ST_DROP) begin
         error_reg <= cfm_pkg::ERR_RESET;
      end else begin
         error_reg.dischg_overcurrent_err <= qual.ocu_above;
         error_reg.chg_overcurrent_err    <= qual.oco_above;
         error_reg.short_circuit_err      <= qual.sc_above;
         if (cells_qual & ~cells_qual_d) begin
            error_reg.under_volt_err <= 1'b0;
         end
      end
   end

   // pins mirror flags a cycle later so they come from flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         int_oe          <= 1'b0;
         err_oe          <= 1'b1;
         short_detect_oe <= 1'b0;
         monitor_active  <= 1'b0;
      end else begin
         int_oe          <= |irq_request_reg;
         err_oe          <= |error_reg;
         short_detect_oe <= error_reg.short_circuit_err;
         monitor_active  <= (state == ST_ACTIVE);
      end
   end

   // pulled-low value is constant; the enable carries the indication
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         int_out          <= 1'b0;
         err_out          <= 1'b0;
         short_detect_out <= 1'b0;
      end else begin
         int_out          <= 1'b0;
         err_out          <= 1'b0;
         short_detect_out <= 1'b0;
      end
   end

   // checks
   a_ocu_req_set: assert property (
      @(posedge mclk) disable iff (!rst_n)
      rise.dischg_overcurrent_req && state != ST_DROP
      |=> irq_request_reg.dischg_overcurrent_req)
      else $error("discharge request not set");
   a_chg_err_set: assert property (
      @(posedge mclk) disable iff (!rst_n)
      rise.chg_overcurrent_req && state != ST_DROP
      |=> error_reg.chg_overcurrent_err)
      else $error("charge error not set");
   a_sc_req_set: assert property (
      @(posedge mclk) disable iff (!rst_n)
      rise.short_circuit_req && state != ST_DROP
      |=> irq_request_reg.short_circuit_req)
      else $error("short request not set");
   a_read_clear: assert property (
      @(posedge mclk) disable iff (!rst_n)
      irq_read && rise == '0 && state != ST_DROP
      |=> irq_request_reg == '0)
      else $error("read did not clear requests");
   a_int_follow: assert property (
      @(posedge mclk) disable iff (!rst_n)
      |irq_request_reg
      |=> int_oe)
      else $error("interrupt pin not driven");
   a_int_release: assert property (
      @(posedge mclk) disable iff (!rst_n)
      irq_request_reg == '0
      |=> !int_oe)
      else $error("interrupt pin held without request");
   a_err_follow: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $rose(qual.ocu_above) && state == ST_ACTIVE
      |=> ##1 err_oe)
      else $error("error pin not driven on fault");
   a_err_combined: assert property (
      @(posedge mclk) disable iff (!rst_n)
      error_reg != '0
      |=> err_oe)
      else $error("error pin released while errors set");
   a_err_release: assert property (
      @(posedge mclk) disable iff (!rst_n)
      error_reg == '0
      |=> !err_oe)
      else $error("error pin held without errors");
   a_no_rel_irq: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $fell(qual.oco_above) && !irq_request_reg.chg_overcurrent_req
      |=> !irq_request_reg.chg_overcurrent_req)
      else $error("release raised a request");
   a_drop_init: assert property (
      @(posedge mclk) disable iff (!rst_n)
      state == ST_DROP
      |=> error_reg.under_volt_err && irq_request_reg == '0)
      else $error("drop did not initialise");
   a_stab_quiet: assert property (
      @(posedge mclk) disable iff (!rst_n)
      state != ST_ACTIVE
      |=> !qual.ocu_above && !qual.wake_above)
      else $error("monitoring outside active state");
   a_wake_gated: assert property (
      @(posedge mclk) disable iff (!rst_n)
      !wake_enable_bit
      |=> !qual.wake_above)
      else $error("wake qualified while disabled");
   a_sc_pin: assert property (
      @(posedge mclk) disable iff (!rst_n)
      error_reg.short_circuit_err
      |=> short_detect_oe)
      else $error("short indicator not driven");
   c_ocu: cover property (@(posedge mclk) disable iff (!rst_n) rise.dischg_overcurrent_req);
   c_sc: cover property (@(posedge mclk) disable iff (!rst_n) rise.short_circuit_req);
   c_wake: cover property (@(posedge mclk) disable iff (!rst_n) rise.wake_event_req);
   c_uv_rel: cover property (@(posedge mclk) disable iff (!rst_n) $fell(error_reg.under_volt_err));
endmodule

// >>> bench/host_mcu.sv
// host controller model: answers the interrupt pin by reading the request flags
`timescale 1ns/1ps
module host_mcu (
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_n,
   // device side
   input  wire logic         int_oe,
   input  cfm_pkg::irq_req_s irq_request_reg,
   output logic              irq_read,
   // bench side
   input  wire logic [3:0]   slow,
   output logic              rd_done,
   output cfm_pkg::irq_req_s rd_data
);
   logic [3:0] lat;
   logic [2:0] cool;

   // cool-down lets the pin fall before the next look, else a stale read
   always @(negedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_read <= 1'b0;
         lat      <= 4'h0;
         cool     <= 3'h0;
      end else if (irq_read) begin
         irq_read <= 1'b0;
         cool     <= 3'h4;
      end else if (cool != 3'h0) begin
         cool <= cool - 3'h1;
      end else if (int_oe === 1'b1 && lat >= slow) begin
         irq_read <= 1'b1;
         lat      <= 4'h0;
      end else if (int_oe === 1'b1) begin
         lat <= lat + 4'h1;
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_done <= 1'b0;
         rd_data <= '0;
      end else begin
         rd_done <= irq_read;
         if (irq_read) rd_data <= irq_request_reg;
      end
   end
endmodule

// >>> bench/current_fault_monitor_tb.sv
// self-checking bench for the current fault monitor
`timescale 1ns/1ps
module current_fault_monitor_tb;
   localparam int unsigned STAB = 8, DET = 10, REL = 12, SCD = 6, WKD = 8, UVR = 10;
   logic                mclk = 1'b0, rst_n = 1'b0, wake_cmp = 1'b0, regulator_ok = 1'b0;
   logic                wake_enable_bit = 1'b0, five_cells = 1'b0;
   logic [2:0]          fc = 3'h0;
   logic [4:0]          cell_above_uvr = 5'h00;
   logic [3:0]          slow = 4'h0;
   logic                irq_read, rd_done, int_out, int_oe, err_out, err_oe;
   logic                short_detect_out, short_detect_oe, monitor_active;
   cfm_pkg::irq_req_s   irq_request_reg, rd_data;
   cfm_pkg::err_flags_s error_reg;
   cfm_pkg::irq_req_s   exp_q[$];
   int                  err_count = 0, checks_done = 0;

   always #2.5 mclk = ~mclk;

   current_fault_monitor #(.STAB_CYC(STAB), .OCU_DET(DET), .OCU_REL(REL), .OCO_DET(DET),
      .OCO_REL(REL), .SC_DET(SCD), .SC_REL(REL), .WK_DET(WKD), .UVR_REL(UVR)) DUT (
      .mclk(mclk), .rst_n(rst_n), .ocu_cmp(fc[0]), .oco_cmp(fc[1]), .sc_cmp(fc[2]),
      .wake_cmp(wake_cmp), .cell_above_uvr(cell_above_uvr), .regulator_ok(regulator_ok),
      .wake_enable_bit(wake_enable_bit), .five_cells(five_cells), .irq_read(irq_read),
      .irq_request_reg(irq_request_reg), .error_reg(error_reg), .int_out(int_out),
      .int_oe(int_oe), .err_out(err_out), .err_oe(err_oe), .short_detect_out(short_detect_out),
      .short_detect_oe(short_detect_oe), .monitor_active(monitor_active));

   host_mcu HOST (.mclk(mclk), .rst_n(rst_n), .int_oe(int_oe),
      .irq_request_reg(irq_request_reg), .irq_read(irq_read), .slow(slow),
      .rd_done(rd_done), .rd_data(rd_data));

   task automatic cmp(input logic [3:0] act, input logic [3:0] exp, input string what);
      checks_done++;
      if (act !== exp) begin
         err_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, act, exp);
      end
   endtask

   task automatic cmp_req(input cfm_pkg::irq_req_s act);
      if (exp_q.size() == 0) cmp(4'h1, 4'h0, "unexpected read");
      else cmp(act, exp_q.pop_front(), "request flags");
   endtask

   task automatic end_sim;
      if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // bounded: a read that never comes is flagged and its note dropped
   task automatic wait_read;
      for (int i = 0; i < 80 && exp_q.size() != 0; i++) tick(1);
      tick(4);
      cmp(4'(exp_q.size()), 4'h0, "host read missing");
      exp_q.delete();
   endtask

   task automatic wait_err(input logic [3:0] e);
      for (int i = 0; i < 80 && error_reg !== e; i++) tick(1);
   endtask

   // read results come back through the host model
   always @(negedge mclk) if (rd_done === 1'b1) cmp_req(rd_data);

   task automatic fault(input int k);
      logic [3:0] m;
      m = 4'h1 << k;
      slow = 4'($urandom_range(0, 15));
      fc[k] = 1'b1; tick(3); fc[k] = 1'b0; tick(2); fc[k] = 1'b1; tick(3); fc[k] = 1'b0;
      tick(6);
      cmp({int_oe, 3'(error_reg)}, 4'h0, "short pulse");
      exp_q.push_back(m);
      fc[k] = 1'b1;
      wait_read;
      cmp(error_reg, m, "error set");
      cmp({err_oe, short_detect_oe, int_oe, |irq_request_reg}, {2'b10, 2'b00} | {1'b0, k == 2,
         2'b00}, "pins in fault");
      cmp({int_out, err_out, short_detect_out, 1'b0}, 4'h0, "pin drive level");
      fc[k] = 1'b0;
      wait_err(4'h0);
      tick(3);
      cmp(error_reg, 4'h0, "error release");
      cmp({err_oe, short_detect_oe, int_oe, |irq_request_reg}, 4'h0, "pins released");
   endtask

   initial begin
      #(5ns * 20000);
      err_count++;
      end_sim;
   end

   initial begin
      void'($urandom(32'h6df1d4f6));
      tick(10);
      rst_n = 1'b1;
      tick(2);
      cmp(error_reg, 4'h8, "reset errors");
      cmp({err_oe, int_oe, short_detect_oe, monitor_active}, 4'h8, "reset pins");
      fc[0] = 1'b1;
      tick(DET + 6);
      cmp({int_oe, 3'(irq_request_reg)}, 4'h0, "fault during drop");
      fc[0] = 1'b0;
      // bottom input is ignored in a four-cell stack, so any level will do
      cell_above_uvr = {4'hf, 1'($urandom)};
      tick(4);
      regulator_ok = 1'b1;
      tick(STAB);
      cmp(4'(monitor_active), 4'h0, "monitor too early");
      for (int i = 0; i < 20 && monitor_active !== 1'b1; i++) tick(1);
      cmp(4'(monitor_active), 4'h1, "monitor start");
      wait_err(4'h0);
      tick(2); // error pin follows the flags one cycle later
      cmp({err_oe, 3'(error_reg)}, 4'h0, "four cell release");
      for (int k = 0; k < 3; k++) fault(k);
      // two errors: pin holds until the last one goes
      slow = 4'hf;
      exp_q.push_back(4'h5);
      fc = 3'h5;
      wait_read;
      fc = 3'h1;
      wait_err(4'h1);
      cmp({err_oe, 3'(error_reg)}, 4'h9, "one error left");
      fc = 3'h0;
      wait_err(4'h0);
      tick(3);
      cmp(4'(err_oe), 4'h0, "all errors gone");
      wake_cmp = 1'b1;
      tick(WKD + 10);
      cmp(4'(int_oe), 4'h0, "wake disabled");
      slow = 4'h2;
      exp_q.push_back(4'h8);
      wake_enable_bit = 1'b1;
      tick(WKD + 6);
      wake_cmp = 1'b0;
      wait_read;
      wake_enable_bit = 1'b0;
      cmp({err_oe, 3'(error_reg)}, 4'h0, "wake keeps errors");
      cmp({int_oe, 3'(irq_request_reg)}, 4'h0, "wake read clears");
      exp_q.push_back(4'h1);
      fc = 3'h1;
      wait_read;
      regulator_ok = 1'b0;
      tick(6);
      cmp(error_reg, 4'h8, "drop errors");
      cmp({err_oe, int_oe, short_detect_oe, |irq_request_reg}, 4'h8, "drop pins");
      fc = 3'h0;
      five_cells = 1'b1;
      cell_above_uvr = 5'h1e;
      regulator_ok = 1'b1;
      tick(STAB + UVR + 20);
      cmp(error_reg, 4'h8, "five cell low");
      cell_above_uvr = 5'h1f;
      wait_err(4'h0);
      tick(2);
      cmp({err_oe, 3'(error_reg)}, 4'h0, "five cell release");
      end_sim;
   end
endmodule
